// *** shared/epic_pkg.sv ***
// Purpose: constants and types of the external pin interrupt controller
// Assumes: one 25 MHz clock, synchronous active-high reset, classic wishbone
// Notes on behaviour
// R1: mask bit 0 lets a source be serviced, mask bit 1 blocks it
// R2: request flag reads 0 when idle, 1 while a request is pending
// R3: priority code 00 is level 0 (highest) up to 11, level 3 (lowest)
// R4: per pin, no enable off, fall only, rise only, both enables both edges
// R5: rising and falling enables are two 8-bit registers, pin n at bit n
// R6: low byte: watchdog bit 0, voltage detect bit 1, pins 0-5 at bits 2-7
// R7: priority low bit and high bit sit in two registers at the same position
// R8: a valid edge sets the flag whatever the mask; flag and open mask request
package epic_pkg;
  localparam int NSRC     = 10;
  localparam int NEXT     = 8;
  localparam int SRC_WDT  = 0;
  localparam int SRC_LVD  = 1;
  localparam int SRC_EXT0 = 2;

  // word byte addresses
  localparam logic [7:0] OFS_MASK_LO = 8'h00;
  localparam logic [7:0] OFS_FLAG_LO = 8'h04;
  localparam logic [7:0] OFS_PRL_LO  = 8'h08;
  localparam logic [7:0] OFS_PRH_LO  = 8'h0C;
  localparam logic [7:0] OFS_RISE    = 8'h10;
  localparam logic [7:0] OFS_FALL    = 8'h14;
  localparam logic [7:0] OFS_MASK_HI = 8'h18;
  localparam logic [7:0] OFS_FLAG_HI = 8'h1C;
  localparam logic [7:0] OFS_PRL_HI  = 8'h20;
  localparam logic [7:0] OFS_PRH_HI  = 8'h24;
  localparam logic [7:0] OFS_STATE   = 8'h28;
  localparam logic [7:0] OFS_ISTS    = 8'h2C;
  localparam logic [7:0] OFS_IEN     = 8'h30;

  localparam logic [NSRC-1:0] RST_MASK = 10'h3FF;
  localparam logic [NSRC-1:0] RST_FLAG = 10'h000;
  localparam logic [NSRC-1:0] RST_PRIO = 10'h3FF;
  localparam logic [NEXT-1:0] RST_EDGE = 8'h00;
  localparam logic [NEXT-1:0] RST_IRQ  = 8'h00;
  localparam logic [NSRC-1:0] ONE_SRC  = 10'h001;

  typedef logic [3:0] epic_src_t;
  typedef logic [1:0] epic_lvl_t;
endpackage

// *** shared/epic_edge_if.sv ***
// Purpose: carries pin levels, edge enables and edge hits
// Assumes: pins already synchronous to clk_i
// Notes: det drives hit, ctl drives the rest
`timescale 1ns/1ns
interface epic_edge_if #(
  parameter int N = 8
);
  logic [N-1:0] pin;
  logic [N-1:0] rise_en;
  logic [N-1:0] fall_en;
  logic [N-1:0] hit;
  modport det (input pin, input rise_en, input fall_en, output hit);
  modport ctl (output pin, output rise_en, output fall_en, input hit);
endinterface

// *** rtl/epic_edge_det.sv ***
// Purpose: per-pin valid edge detection
// Assumes: pins synchronous to clk_i
// Notes: no hit in the first cycle after reset, avoids a false edge
`timescale 1ns/1ns
module epic_edge_det #(
  parameter int N = 8
) (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  epic_edge_if.det    bus
);
  logic armed_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      logic prev_q;
      wire  rose;
      wire  fell;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          prev_q <= 1'b0;
        end else begin
          prev_q <= bus.pin[g];
        end
      end
      assign rose = armed_q & bus.pin[g] & ~prev_q;
      assign fell = armed_q & ~bus.pin[g] & prev_q;
      assign bus.hit[g] = (bus.rise_en[g] & rose) | (bus.fall_en[g] & fell); // [R4]
    end
  endgenerate

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_edge_none : assert property ( // [R4]
    !bus.rise_en[0] && !bus.fall_en[0] |-> !bus.hit[0])
    else $error("edge seen with detection off");
  chk_edge_rise : assert property ( // [R4]
    armed_q && bus.rise_en[0] && $rose(bus.pin[0]) |-> bus.hit[0])
    else $error("enabled rising edge missed");
  chk_edge_fall : assert property ( // [R4]
    !bus.fall_en[0] && $fell(bus.pin[0]) |-> !bus.hit[0])
    else $error("falling edge taken while disabled");
endmodule

// *** rtl/epic_top.sv ***
// Purpose: external pin interrupt requests, masks, priorities, edge select
// Assumes: classic wishbone slave, 25 MHz clk_i, rst_i synchronous high
// Notes: req_o flags and req_src_o names the best pending source for the cpu acknowledge logic
`timescale 1ns/1ns
module epic_top
  import epic_pkg::*;
#(
  parameter int AW = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [AW-1:0]    wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic [7:0]       ext_pin_i,
  input  wire logic             wdt_evt_i,
  input  wire logic             lvd_evt_i,
  input  wire logic             cpu_ack_i,
  input  wire epic_pkg::epic_src_t cpu_ack_src_i,
  output logic                  req_o,
  output epic_pkg::epic_src_t   req_src_o,
  output epic_pkg::epic_lvl_t   req_lvl_o,
  output logic                  irq_o
);
  import epic_pkg::*;

  logic [NSRC-1:0] mask_q;
  logic [NSRC-1:0] mask_d;
  logic [NSRC-1:0] flag_q;
  logic [NSRC-1:0] flag_d;
  logic [NSRC-1:0] flag_w;
  logic [NSRC-1:0] prl_q;
  logic [NSRC-1:0] prl_d;
  logic [NSRC-1:0] prh_q;
  logic [NSRC-1:0] prh_d;
  logic [NEXT-1:0] rise_q;
  logic [NEXT-1:0] rise_d;
  logic [NEXT-1:0] fall_q;
  logic [NEXT-1:0] fall_d;
  logic [NEXT-1:0] ists_q;
  logic [NEXT-1:0] ists_d;
  logic [NEXT-1:0] ien_q;
  logic [NEXT-1:0] ien_d;
  logic            ack_q;
  logic [31:0]     dat_q;
  logic            req_q;
  epic_src_t       src_q;
  epic_lvl_t       lvl_q;
  logic            irq_q;

  // edge detection
  epic_edge_if #(.N(NEXT)) edge_bus ();
  assign edge_bus.pin     = ext_pin_i;
  assign edge_bus.rise_en = rise_q;
  assign edge_bus.fall_en = fall_q;

  epic_edge_det #(.N(NEXT)) u_det (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (edge_bus.det)
  );

  wire [NEXT-1:0] ext_hit = edge_bus.hit;

  // bus decode
  wire       bus_req = wb_cyc_i & wb_stb_i;
  wire       rd_new  = bus_req & ~ack_q;
  wire       wr_stb  = bus_req & wb_we_i & ack_q & wb_sel_i[0];
  wire       in_page = (wb_adr_i >> 8) == '0;
  wire [7:0] ofs     = {wb_adr_i[7:2], 2'h0};
  wire [7:0] wd      = wb_dat_i[7:0];

  wire sel_mask_lo = in_page && (ofs == OFS_MASK_LO);
  wire sel_flag_lo = in_page && (ofs == OFS_FLAG_LO);
  wire sel_prl_lo  = in_page && (ofs == OFS_PRL_LO);
  wire sel_prh_lo  = in_page && (ofs == OFS_PRH_LO);
  wire sel_rise    = in_page && (ofs == OFS_RISE);
  wire sel_fall    = in_page && (ofs == OFS_FALL);
  wire sel_mask_hi = in_page && (ofs == OFS_MASK_HI);
  wire sel_flag_hi = in_page && (ofs == OFS_FLAG_HI);
  wire sel_prl_hi  = in_page && (ofs == OFS_PRL_HI);
  wire sel_prh_hi  = in_page && (ofs == OFS_PRH_HI);
  wire sel_state   = in_page && (ofs == OFS_STATE);
  wire sel_ists    = in_page && (ofs == OFS_ISTS);
  wire sel_ien     = in_page && (ofs == OFS_IEN);

  // low byte: watchdog, voltage detect, pins 0..5; high byte: pins 6..7
  assign mask_d[7:0] = (wr_stb && sel_mask_lo) ? wd : mask_q[7:0]; // [R6]
  assign mask_d[9:8] = (wr_stb && sel_mask_hi) ? wd[1:0] : mask_q[9:8];
  assign prl_d[7:0]  = (wr_stb && sel_prl_lo) ? wd : prl_q[7:0]; // [R7]
  assign prl_d[9:8]  = (wr_stb && sel_prl_hi) ? wd[1:0] : prl_q[9:8];
  assign prh_d[7:0]  = (wr_stb && sel_prh_lo) ? wd : prh_q[7:0]; // [R7]
  assign prh_d[9:8]  = (wr_stb && sel_prh_hi) ? wd[1:0] : prh_q[9:8];
  assign rise_d      = (wr_stb && sel_rise) ? wd : rise_q; // [R5]
  assign fall_d      = (wr_stb && sel_fall) ? wd : fall_q; // [R5]
  assign ien_d       = (wr_stb && sel_ien) ? wd : ien_q;

  // request flags: a new event beats a software write or a cpu acknowledge
  wire [NSRC-1:0] src_set = {ext_hit, lvd_evt_i, wdt_evt_i};
  wire [NSRC-1:0] ack_clr = cpu_ack_i ? (ONE_SRC << cpu_ack_src_i) : '0;
  assign flag_w[7:0] = (wr_stb && sel_flag_lo) ? wd : flag_q[7:0];
  assign flag_w[9:8] = (wr_stb && sel_flag_hi) ? wd[1:0] : flag_q[9:8];
  assign flag_d = (flag_w & ~ack_clr) | src_set; // [R2] [R8]

  // interrupt status: write one to clear, a same-cycle hit wins
  wire [NEXT-1:0] ists_clr = (wr_stb && sel_ists) ? wd : '0;
  assign ists_d = (ists_q & ~ists_clr) | ext_hit;

  // best pending source: lowest level number, then lowest index
  wire [NSRC-1:0] pend = flag_q & ~mask_q; // [R1] [R8]
  logic      best_found;
  epic_src_t best_src;
  epic_lvl_t best_lvl;
  epic_lvl_t cur_lvl;
  always_comb begin
    best_found = 1'b0;
    best_src   = '0;
    best_lvl   = 2'h3;
    cur_lvl    = 2'h3;
    for (int i = 0; i < NSRC; i++) begin
      cur_lvl = {prh_q[i], prl_q[i]}; // [R7]
      if (pend[i] && (!best_found || cur_lvl < best_lvl)) begin // [R3]
        best_found = 1'b1;
        best_src   = epic_src_t'(i);
        best_lvl   = cur_lvl;
      end
    end
  end

  // read selection
  wire [31:0] rd_data =
    sel_mask_lo ? {24'h0, mask_q[7:0]} :
    sel_flag_lo ? {24'h0, flag_q[7:0]} :
    sel_prl_lo  ? {24'h0, prl_q[7:0]} :
    sel_prh_lo  ? {24'h0, prh_q[7:0]} :
    sel_rise    ? {24'h0, rise_q} :
    sel_fall    ? {24'h0, fall_q} :
    sel_mask_hi ? {30'h0, mask_q[9:8]} :
    sel_flag_hi ? {30'h0, flag_q[9:8]} :
    sel_prl_hi  ? {30'h0, prl_q[9:8]} :
    sel_prh_hi  ? {30'h0, prh_q[9:8]} :
    sel_state   ? {25'h0, req_q, lvl_q, src_q} :
    sel_ists    ? {24'h0, ists_q} :
    sel_ien     ? {24'h0, ien_q} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= RST_MASK;
      flag_q <= RST_FLAG;
      prl_q  <= RST_PRIO;
      prh_q  <= RST_PRIO;
      rise_q <= RST_EDGE;
      fall_q <= RST_EDGE;
      ists_q <= RST_IRQ;
      ien_q  <= RST_IRQ;
    end else begin
      mask_q <= mask_d;
      flag_q <= flag_d;
      prl_q  <= prl_d;
      prh_q  <= prh_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      ists_q <= ists_d;
      ien_q  <= ien_d;
    end
  end

  // one wait state: ack the cycle after the request, data held in a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= rd_new;
      dat_q <= rd_new ? rd_data : dat_q;
    end
  end

  // outputs registered, one cycle behind the flags they reflect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= 1'b0;
      src_q <= '0;
      lvl_q <= 2'h3;
      irq_q <= 1'b0;
    end else begin
      req_q <= best_found; // [R1]
      src_q <= best_src;
      lvl_q <= best_lvl; // [R3]
      irq_q <= |(ists_q & ien_q);
    end
  end

  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = dat_q;
  assign req_o     = req_q;
  assign req_src_o = src_q;
  assign req_lvl_o = lvl_q;
  assign irq_o     = irq_q;

  // checks
  wire any_lvl0 = |(pend & ~prh_q & ~prl_q);
  wire only_l3  = (pend != '0) && ((pend & ~(prh_q & prl_q)) == '0);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_mask_blocks : assert property ( // [R1]
    pend == '0 |=> !req_o)
    else $error("request shown with every source masked");
  chk_open_request : assert property ( // [R1]
    pend != '0 |=> req_o && ((($past(pend) >> req_src_o) & ONE_SRC) != '0))
    else $error("open pending source not presented");
  chk_flag_set : assert property ( // [R2]
    ext_hit != '0 |=> (flag_q[9:2] & $past(ext_hit)) == $past(ext_hit))
    else $error("edge did not set its flag");
  chk_flag_unmasked : assert property ( // [R8]
    ext_hit[0] && mask_q[SRC_EXT0] |=> flag_q[SRC_EXT0] && !req_o || pend != '0)
    else $error("masked edge lost its flag");
  chk_level_zero : assert property ( // [R3]
    any_lvl0 |=> req_lvl_o == 2'h0)
    else $error("level 0 source not chosen first");
  chk_level_three : assert property ( // [R3]
    only_l3 |=> req_lvl_o == 2'h3)
    else $error("wrong level for lowest priority");
  chk_rise_write : assert property ( // [R5]
    wr_stb && sel_rise |=> rise_q == $past(wd))
    else $error("rising enables not written");
  chk_mask_layout : assert property ( // [R6]
    rd_new && sel_mask_lo |=> wb_ack_o && wb_dat_o[7:0] == $past(mask_q[7:0]))
    else $error("low mask byte read wrong");
  chk_prio_split : assert property ( // [R7]
    wr_stb && sel_prl_lo |=> prl_q[7:0] == $past(wd) && prh_q == $past(prh_q))
    else $error("priority low write touched high bits");

  // bus handshake
  chk_ack_answer : assert property (
    rd_new |=> wb_ack_o)
    else $error("request not answered in one cycle");
  chk_ack_single : assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_state_read : assert property ( // [R3]
    rd_new && sel_state |=> wb_dat_o == {25'h0, $past(req_q), $past(lvl_q), $past(src_q)})
    else $error("state word read wrong");

  // register writes
  chk_fall_write : assert property ( // [R5]
    wr_stb && sel_fall |=> fall_q == $past(wd))
    else $error("falling enables not written");
  chk_mask_write : assert property ( // [R6]
    wr_stb && sel_mask_lo |=> mask_q[7:0] == $past(wd))
    else $error("low mask byte not written");
  chk_mask_high : assert property ( // [R6]
    wr_stb && sel_mask_hi |=> mask_q[9:8] == $past(wd[1:0]))
    else $error("high mask bits not written");
  chk_prh_split : assert property ( // [R7]
    wr_stb && sel_prh_lo |=> prh_q[7:0] == $past(wd) && prl_q == $past(prl_q))
    else $error("priority high write touched low bits");
  chk_prl_high : assert property ( // [R7]
    wr_stb && sel_prl_hi |=> prl_q[9:8] == $past(wd[1:0]))
    else $error("high group priority low bits not written");
  chk_prh_high : assert property ( // [R7]
    wr_stb && sel_prh_hi |=> prh_q[9:8] == $past(wd[1:0]))
    else $error("high group priority high bits not written");
  chk_ien_write : assert property (
    wr_stb && sel_ien |=> ien_q == $past(wd))
    else $error("interrupt enables not written");

  // flags and outputs
  chk_flag_write : assert property ( // [R2]
    wr_stb && sel_flag_lo && !cpu_ack_i && src_set[7:0] == '0 |=> flag_q[7:0] == $past(wd))
    else $error("low flag byte not written");
  chk_flag_hold : assert property ( // [R2]
    flag_q[SRC_EXT0] && !cpu_ack_i && !(wr_stb && sel_flag_lo) |=> flag_q[SRC_EXT0])
    else $error("pending flag dropped on its own");
  chk_flag_idle : assert property ( // [R2]
    !flag_q[SRC_EXT0] && !ext_hit[0] && !(wr_stb && sel_flag_lo) |=> !flag_q[SRC_EXT0])
    else $error("flag set with no event");
  chk_wdt_flag : assert property ( // [R6]
    wdt_evt_i |=> flag_q[SRC_WDT])
    else $error("watchdog event not at flag bit 0");
  chk_lvd_flag : assert property ( // [R6]
    lvd_evt_i |=> flag_q[SRC_LVD])
    else $error("voltage detect event not at flag bit 1");
  chk_cpu_clear : assert property ( // [R8]
    cpu_ack_i && cpu_ack_src_i == epic_src_t'(SRC_EXT0) && !ext_hit[0] |=> !flag_q[SRC_EXT0])
    else $error("cpu acknowledge left the flag set");
  chk_src_range : assert property ( // [R1]
    req_o |-> req_src_o <= epic_src_t'(NSRC - 1))
    else $error("request names a source that does not exist");
  chk_ists_sticky : assert property (
    ists_q[0] && !(wr_stb && sel_ists && wd[0]) |=> ists_q[0])
    else $error("status bit lost without a clear");
  chk_irq_follow : assert property (
    1'b1 |=> irq_o == $past(|(ists_q & ien_q)))
    else $error("interrupt output does not follow status");

  cov_bus_write : cover property (wr_stb && sel_rise);
  cov_masked_edge : cover property (ext_hit[0] && mask_q[SRC_EXT0]);
  cov_request   : cover property (!req_o ##1 req_o);
  cov_irq       : cover property ($rose(irq_o));
  cov_ack_clear : cover property (cpu_ack_i && req_o);
endmodule

// *** bench/epic_cpu_model.sv ***
// Purpose: cpu side that takes the best pending request
// Assumes: one clock shared with the controller
// Notes: answers dly cycles after req, then rests while the flag drains
`timescale 1ns/1ns
module epic_cpu_model
  import epic_pkg::*;
#(
  parameter int DLY = 2
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                en_i,
  input  wire logic                req_i,
  input  wire epic_pkg::epic_src_t src_i,
  output logic                     ack_o,
  output epic_pkg::epic_src_t      ack_src_o
);
  int cnt = 0;
  initial ack_o = 1'b0;
  initial ack_src_o = 4'h0;
  // rest after an ack: req stays up two cycles while the flag clears
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    if (rst_i || !en_i || !req_i) begin
      cnt <= 0;
    end else if (cnt == DLY) begin
      ack_o     <= 1'b1;
      ack_src_o <= src_i;
      cnt       <= -4;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// *** bench/epic_top_bench.sv ***
// Purpose: self-checking bench of the pin interrupt controller
// Assumes: 25 MHz clock, wishbone ack one cycle after the request
// Notes: fixed waits follow the flag and req latencies of the design
`timescale 1ns/1ns
module epic_top_bench;
  import epic_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic        cpu_en = 0, wdt = 0, lvd = 0, ack, req, irq, cack;
  logic [7:0]  adr = 8'h00, pins = 8'h00;
  logic [31:0] dat = 32'h0, rdat, dat_o;
  epic_src_t   src, csrc;
  epic_lvl_t   lvl;
  int          n_fail = 0, compares = 0, cycles = 0;
  always #20 clk_i = ~clk_i;
  epic_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .ext_pin_i(pins), .wdt_evt_i(wdt), .lvd_evt_i(lvd),
    .cpu_ack_i(cack), .cpu_ack_src_i(csrc), .req_o(req), .req_src_o(src),
    .req_lvl_o(lvl), .irq_o(irq));
  epic_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .en_i(cpu_en), .req_i(req),
    .src_i(src), .ack_o(cack), .ack_src_o(csrc));
  task results;
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, well past the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  // pin change, then wait for flag (c1) and req (c2) to land
  task step(input logic [7:0] v);
    @(posedge clk_i);
    pins <= v;
    repeat (3) @(posedge clk_i);
  endtask
  task t_reset;
    wb(0, OFS_MASK_LO, 0); chk(rdat, 32'hFF);
    wb(0, OFS_FLAG_LO, 0); chk(rdat, 32'h0);
    wb(0, OFS_PRH_LO, 0); chk(rdat, 32'hFF);
    wb(0, OFS_FALL, 0); chk(rdat, 32'h0);
    wb(0, 8'h3C, 0); chk(rdat, 32'h0);
  endtask
  task t_edges;
    for (int m = 0; m < 4; m++) begin
      wb(1, OFS_RISE, {31'h0, m[1]});
      wb(1, OFS_FALL, {31'h0, m[0]});
      step(8'h01);
      wb(0, OFS_FLAG_LO, 0); chk(rdat, {29'h0, m[1], 2'h0});
      chk({31'h0, req}, 32'h0);
      wb(1, OFS_FLAG_LO, 0);
      step(8'h00);
      wb(0, OFS_FLAG_LO, 0); chk(rdat, {29'h0, m[0], 2'h0});
      wb(1, OFS_FLAG_LO, 0);
    end
  endtask
  task t_events;
    @(posedge clk_i) wdt <= 1'b1;
    @(posedge clk_i) wdt <= 1'b0;
    lvd <= 1'b1;
    @(posedge clk_i) lvd <= 1'b0;
    wb(1, OFS_RISE, 32'h40);
    step(8'h40);
    wb(0, OFS_FLAG_LO, 0); chk(rdat, 32'h3);
    wb(0, OFS_FLAG_HI, 0); chk(rdat, 32'h1);
    wb(1, OFS_FLAG_LO, 0);
    wb(1, OFS_FLAG_HI, 0);
    step(8'h00);
  endtask
  task t_prio;
    wb(1, OFS_RISE, 32'h1);
    wb(1, OFS_MASK_LO, 32'hFB);
    for (int l = 0; l < 4; l++) begin
      wb(1, OFS_PRL_LO, {27'h1F, l[0], 2'h3});
      wb(1, OFS_PRH_LO, {27'h1F, l[1], 2'h3});
      step(8'h01);
      chk({31'h0, req}, 32'h1);
      chk({28'h0, src}, 32'h2);
      chk({30'h0, lvl}, {30'h0, l[1:0]});
      wb(0, OFS_STATE, 0); chk(rdat, {25'h0, 1'b1, l[1:0], 4'h2});
      @(posedge clk_i) cpu_en <= 1'b1;
      repeat (10) @(posedge clk_i);
      chk({31'h0, req}, 32'h0);
      wb(0, OFS_FLAG_LO, 0); chk(rdat, 32'h0);
      cpu_en <= 1'b0;
      step(8'h00);
    end
  endtask
  task t_irq;
    wb(1, OFS_ISTS, 32'hFF);
    wb(1, OFS_IEN, 32'h1);
    step(8'h01);
    chk({31'h0, irq}, 32'h1);
    wb(0, OFS_ISTS, 0); chk(rdat, 32'h1);
    wb(1, OFS_IEN, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    wb(1, OFS_IEN, 32'h1);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    wb(1, OFS_ISTS, 32'h1);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_edges();
    t_events();
    t_prio();
    t_irq();
    results();
  end
endmodule
